// ===== core/vfref_params.svh
// vfref_params.svh: register indexes, reset values, scales and timing constants
// assumes: included by the package file only; the modules of the v/f reference block use its macros without including it
`ifndef VFREF_PARAMS_SVH
`define VFREF_PARAMS_SVH

// register indexes on the plain register port
`define VFREF_REG_CURVE 5'h00
`define VFREF_REG_BOOST 5'h01
`define VFREF_REG_CUTOFF 5'h02
`define VFREF_REG_P1F 5'h03
`define VFREF_REG_P1V 5'h04
`define VFREF_REG_P2F 5'h05
`define VFREF_REG_P2V 5'h06
`define VFREF_REG_P3F 5'h07
`define VFREF_REG_P3V 5'h08
`define VFREF_REG_SLIP 5'h09
`define VFREF_REG_OVX 5'h0A
`define VFREF_REG_OSC 5'h0B
`define VFREF_REG_SRC 5'h0D
`define VFREF_REG_SETPT 5'h0E
`define VFREF_REG_RISE 5'h0F
`define VFREF_REG_RATED_V 5'h10
`define VFREF_REG_RATED_F 5'h11
`define VFREF_REG_RATED_RPM 5'h12
`define VFREF_REG_POLES 5'h13
`define VFREF_REG_STATOR_RS 5'h14
`define VFREF_REG_VOLT_STAT 5'h15
`define VFREF_REG_FREQ_STAT 5'h16
`define VFREF_REG_MSTEP 5'h17
`define VFREF_NUM_CFG 24

// reset values
`define VFREF_RST_CUTOFF 16'h1388
`define VFREF_RST_RATED_V 16'h0DC0
`define VFREF_RST_RATED_F 16'h1388
`define VFREF_RST_RATED_RPM 16'h05B4
`define VFREF_RST_POLES 16'h0002

// curve shape and source codes
`define VFREF_CRV_LINEAR 4'h0
`define VFREF_CRV_MULTI 4'h1
`define VFREF_CRV_SQUARE 4'h2
`define VFREF_CRV_PWR12 4'h3
`define VFREF_CRV_PWR14 4'h4
`define VFREF_CRV_PWR16 4'h6
`define VFREF_CRV_PWR18 4'h8
`define VFREF_CRV_SEP_FULL 4'hA
`define VFREF_CRV_SEP_SEMI 4'hB
`define VFREF_SRC_DIGITAL 4'h0
`define VFREF_SRC_MAX 4'h8

// scales: percent fields are in 0.1 %, gains are plain counts
`define VFREF_PM_FULL 48'h3E8
`define VFREF_BOOST_MAX 48'h12C
`define VFREF_SLIP_MAX 48'h7D0
`define VFREF_OVX_MAX 48'hC8
`define VFREF_OSC_MAX 48'h64
`define VFREF_AUTO_BOOST_SHIFT 4
`define VFREF_FRAC_BITS 16

// timing
`define VFREF_CLK_MHZ 200
`define VFREF_CTRL_PERIOD_US 100
`define VFREF_CTRL_CYCLES (`VFREF_CTRL_PERIOD_US * `VFREF_CLK_MHZ)
`define VFREF_PULSE_GATE_US 1000
`define VFREF_PULSE_GATE_CYCLES (`VFREF_PULSE_GATE_US * `VFREF_CLK_MHZ)
`define VFREF_PULSE_FULL_KHZ 100
`define VFREF_PULSE_FULL_EDGES (`VFREF_PULSE_FULL_KHZ * `VFREF_PULSE_GATE_US / 1000)
`define VFREF_RISE_UNITS_PER_S 10

`endif

// ===== core/vfref_pkg.sv
// vfref_pkg: carrier types of the v/f reference block
// assumes: nothing beyond the params header
`include "vfref_params.svh"

package vfref_pkg;
    // source percentages, signed, 0.1 % units
    typedef struct packed {
        logic signed [15:0] analog_in_one;
        logic signed [15:0] analog_in_two;
        logic signed [15:0] analog_in_three;
        logic signed [15:0] sequencer;
        logic signed [15:0] pid;
        logic signed [15:0] comm;
    } vfref_src_t;

    // command to the modulator: 0.1 V and 0.01 Hz
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] freq;
    } vfref_cmd_t;
endpackage

// ===== core/vfref_mstep_mem.sv
// vfref_mstep_mem: multi-step voltage table, one write port, registered read
// assumes: single clock, read address already synchronised
`timescale 1ns/1ps
`default_nettype none

module vfref_mstep_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4,
    parameter int DW = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_q [DEPTH];

    // no reset on the array so it can map to ram; contents are software's
    always_ff @(posedge i_sys_clk) begin
        if (i_wr) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem_q[i_raddr];
        end
    end
endmodule

`default_nettype wire

// ===== core/vfref_gen.sv
// vfref_gen: voltage-versus-frequency reference generator for scalar control
// assumes: one 200 MHz clock, frequency command and sources on that clock,
// pulse and multi-step pins asynchronous
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module vfref_gen
    import vfref_pkg::*;
#(
    parameter int CTRL_CYCLES = `VFREF_CTRL_CYCLES,
    parameter int PULSE_GATE_CYCLES = `VFREF_PULSE_GATE_CYCLES,
    parameter int MSTEP_DEPTH = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [4:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    input wire logic i_vector_mode,
    input wire logic i_decel,
    input wire logic [15:0] i_freq_cmd,
    input wire logic [15:0] i_load_pct,
    input wire logic signed [15:0] i_osc_current,
    input wire vfref_src_t i_src,
    input wire logic i_pulse_input_pin,
    input wire logic [3:0] i_mstep_pins,
    output vfref_cmd_t o_cmd,
    output logic o_vf_active
);
    typedef logic signed [47:0] w_t;

    ////////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] cfg_q [`VFREF_NUM_CFG];
    logic [15:0] mstep_rdata;
    logic mstep_wr;

    assign mstep_wr = i_reg_wr && (i_reg_addr == `VFREF_REG_MSTEP);

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int k = 0; k < `VFREF_NUM_CFG; k++) begin
                cfg_q[k] <= 16'h0000;
            end
            cfg_q[`VFREF_REG_CUTOFF] <= `VFREF_RST_CUTOFF;
            cfg_q[`VFREF_REG_RATED_V] <= `VFREF_RST_RATED_V;
            cfg_q[`VFREF_REG_RATED_F] <= `VFREF_RST_RATED_F;
            cfg_q[`VFREF_REG_RATED_RPM] <= `VFREF_RST_RATED_RPM;
            cfg_q[`VFREF_REG_POLES] <= `VFREF_RST_POLES;
        end else if (i_reg_wr && i_reg_addr < 5'(`VFREF_NUM_CFG) && !mstep_wr
                     && i_reg_addr != `VFREF_REG_VOLT_STAT && i_reg_addr != `VFREF_REG_FREQ_STAT) begin
            cfg_q[i_reg_addr] <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `VFREF_REG_VOLT_STAT: o_reg_rdata <= o_cmd.volt;
                `VFREF_REG_FREQ_STAT: o_reg_rdata <= o_cmd.freq;
                `VFREF_REG_MSTEP: o_reg_rdata <= 16'h0000;
                default: o_reg_rdata <= (i_reg_addr < 5'(`VFREF_NUM_CFG)) ? cfg_q[i_reg_addr] : 16'h0000;
            endcase
        end else begin
            o_reg_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, control tick, pulse frequency gate
    logic [1:0] pulse_sync_q;
    logic pulse_prev_q;
    logic [3:0] mstep_s1_q;
    logic [3:0] mstep_s2_q;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [31:0] gate_cnt_q;
    logic [15:0] edge_cnt_q;
    logic [15:0] pulse_pct_q;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pulse_sync_q <= 2'h0;
            pulse_prev_q <= 1'b0;
            mstep_s1_q <= 4'h0;
            mstep_s2_q <= 4'h0;
        end else begin
            pulse_sync_q <= {pulse_sync_q[0], i_pulse_input_pin};
            pulse_prev_q <= pulse_sync_q[1];
            mstep_s1_q <= i_mstep_pins;
            mstep_s2_q <= mstep_s1_q;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == 32'(CTRL_CYCLES - 1));
            tick_cnt_q <= (tick_cnt_q == 32'(CTRL_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        end
    end

    // edges counted over a fixed gate; full-scale pulse rate reads as 100.0 %
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gate_cnt_q <= 32'h0000_0000;
            edge_cnt_q <= 16'h0000;
            pulse_pct_q <= 16'h0000;
        end else if (gate_cnt_q == 32'(PULSE_GATE_CYCLES - 1)) begin
            gate_cnt_q <= 32'h0000_0000;
            edge_cnt_q <= 16'h0000;
            pulse_pct_q <= 16'(w_t'(edge_cnt_q) * `VFREF_PM_FULL / `VFREF_PULSE_FULL_EDGES);
        end else begin
            gate_cnt_q <= gate_cnt_q + 32'h0000_0001;
            if (pulse_sync_q[1] && !pulse_prev_q && edge_cnt_q != 16'hFFFF) begin
                edge_cnt_q <= edge_cnt_q + 16'h0001;
            end
        end
    end

    vfref_mstep_mem #(
        .DEPTH(MSTEP_DEPTH),
        .AW(4),
        .DW(16)
    ) u_mstep (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr(mstep_wr),
        .i_waddr(i_reg_wdata[15:12]),
        .i_wdata({4'h0, i_reg_wdata[11:0]}),
        .i_raddr(mstep_s2_q),
        .o_rdata(mstep_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic w_t lim(input w_t x, input w_t lo, input w_t hi);
        lim = (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction

    function automatic w_t interp(input w_t x, input w_t x0, input w_t x1, input w_t y0, input w_t y1);
        interp = (x1 <= x0) ? y1 : y0 + (y1 - y0) * (x - x0) / (x1 - x0);
    endfunction

    function automatic w_t mag(input logic signed [15:0] v);
        mag = (v < 0) ? -w_t'(v) : w_t'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // curve and separation arithmetic
    logic [3:0] shape;
    logic [3:0] src_sel;
    logic sep_full;
    logic sep_semi;
    w_t vb, fb, f, p, sq, crv_pm, f1, f2, f3, v1, v2, v3;
    w_t sep_pct, sep_volt, curve_volt, boost_pm, boost_add, base, ovx_add, osc_sub, volt_d;
    w_t slip_rated, freq_d, ramp_step, ramp_tgt;

    assign shape = cfg_q[`VFREF_REG_CURVE][3:0];
    assign src_sel = cfg_q[`VFREF_REG_SRC][3:0];
    assign sep_full = (shape == `VFREF_CRV_SEP_FULL);
    assign sep_semi = (shape == `VFREF_CRV_SEP_SEMI);

    always_comb begin
        vb = w_t'(cfg_q[`VFREF_REG_RATED_V]);
        fb = lim(w_t'(cfg_q[`VFREF_REG_RATED_F]), 48'h1, 48'hFFFF);
        f = w_t'(i_freq_cmd);
        p = (f >= fb) ? `VFREF_PM_FULL : f * `VFREF_PM_FULL / fb;
        sq = p * p / `VFREF_PM_FULL;
        // points kept ordered whatever software wrote
        f3 = lim(w_t'(cfg_q[`VFREF_REG_P3F]), 48'h0, fb);
        f2 = lim(w_t'(cfg_q[`VFREF_REG_P2F]), 48'h0, f3);
        f1 = lim(w_t'(cfg_q[`VFREF_REG_P1F]), 48'h0, f2);
        v1 = lim(w_t'(cfg_q[`VFREF_REG_P1V]), 48'h0, `VFREF_PM_FULL);
        v2 = lim(w_t'(cfg_q[`VFREF_REG_P2V]), 48'h0, `VFREF_PM_FULL);
        v3 = lim(w_t'(cfg_q[`VFREF_REG_P3V]), 48'h0, `VFREF_PM_FULL);
        // power curves are a blend of linear and square, weight (exp-1)/1
        case (shape)
            `VFREF_CRV_LINEAR: crv_pm = p;
            `VFREF_CRV_SQUARE: crv_pm = sq;
            `VFREF_CRV_PWR12: crv_pm = p - (p - sq) * 48'h2 / 48'hA;
            `VFREF_CRV_PWR14: crv_pm = p - (p - sq) * 48'h4 / 48'hA;
            `VFREF_CRV_PWR16: crv_pm = p - (p - sq) * 48'h6 / 48'hA;
            `VFREF_CRV_PWR18: crv_pm = p - (p - sq) * 48'h8 / 48'hA;
            `VFREF_CRV_MULTI: begin
                if (f <= f1) begin
                    crv_pm = interp(f, 48'h0, f1, 48'h0, v1);
                end else if (f <= f2) begin
                    crv_pm = interp(f, f1, f2, v1, v2);
                end else if (f <= f3) begin
                    crv_pm = interp(f, f2, f3, v2, v3);
                end else begin
                    crv_pm = interp(lim(f, 48'h0, fb), f3, fb, v3, `VFREF_PM_FULL);
                end
            end
            // reserved and unknown codes give no curve voltage; boost is still added below cut-off
            default: crv_pm = 48'h0;
        endcase
        curve_volt = crv_pm * vb / `VFREF_PM_FULL;

        // separation source magnitude, 0.1 % of rated voltage
        case (src_sel)
            4'h1: sep_pct = mag(i_src.analog_in_one);
            4'h2: sep_pct = mag(i_src.analog_in_two);
            4'h3: sep_pct = mag(i_src.analog_in_three);
            4'h4: sep_pct = w_t'(pulse_pct_q);
            4'h5: sep_pct = w_t'(mstep_rdata);
            4'h6: sep_pct = mag(i_src.sequencer);
            4'h7: sep_pct = mag(i_src.pid);
            4'h8: sep_pct = mag(i_src.comm);
            default: sep_pct = 48'h0;
        endcase
        sep_pct = lim(sep_pct, 48'h0, `VFREF_PM_FULL);
        if (src_sel == `VFREF_SRC_DIGITAL) begin
            sep_volt = lim(w_t'(cfg_q[`VFREF_REG_SETPT]), 48'h0, vb);
        end else begin
            sep_volt = sep_pct * vb / `VFREF_PM_FULL;
        end
        // semi separation: ratio 2*X*vb/fb applied to frequency
        if (sep_semi) begin
            ramp_tgt = 48'h2 * sep_pct * vb * f / (`VFREF_PM_FULL * fb);
        end else begin
            ramp_tgt = sep_volt;
        end
        ramp_tgt = lim(ramp_tgt, 48'h0, vb);
        // step per period: vb over the rise time, fixed point
        if (cfg_q[`VFREF_REG_RISE] == 16'h0000) begin
            ramp_step = vb <<< `VFREF_FRAC_BITS;
        end else begin
            ramp_step = (vb <<< `VFREF_FRAC_BITS) * w_t'(CTRL_CYCLES)
                / (w_t'(cfg_q[`VFREF_REG_RISE]) * w_t'(`VFREF_CLK_MHZ) * 48'hF4240
                / w_t'(`VFREF_RISE_UNITS_PER_S));
            ramp_step = lim(ramp_step, 48'h1, vb <<< `VFREF_FRAC_BITS);
        end

        // boost: zero setting switches to automatic from stator resistance
        if (cfg_q[`VFREF_REG_BOOST] == 16'h0000) begin
            boost_pm = lim(w_t'(cfg_q[`VFREF_REG_STATOR_RS]) >>> `VFREF_AUTO_BOOST_SHIFT, 48'h0, `VFREF_BOOST_MAX);
        end else begin
            boost_pm = lim(w_t'(cfg_q[`VFREF_REG_BOOST]), 48'h0, `VFREF_BOOST_MAX);
        end
        boost_add = (f < w_t'(cfg_q[`VFREF_REG_CUTOFF])) ? boost_pm * vb / `VFREF_PM_FULL : 48'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // voltage ramp for separation modes
    logic [47:0] ramp_q;
    w_t ramp_now;

    assign ramp_now = w_t'(ramp_q) >>> `VFREF_FRAC_BITS;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ramp_q <= 48'h0;
        end else if (tick_q) begin
            if (!(sep_full || sep_semi)) begin
                // track the output so entering separation does not jump
                ramp_q <= 48'(w_t'(o_cmd.volt) <<< `VFREF_FRAC_BITS);
            end else if ((w_t'(ramp_q) + ramp_step) <= (ramp_tgt <<< `VFREF_FRAC_BITS)) begin
                ramp_q <= 48'(w_t'(ramp_q) + ramp_step);
            end else if (w_t'(ramp_q) >= (ramp_tgt <<< `VFREF_FRAC_BITS) + ramp_step) begin
                ramp_q <= 48'(w_t'(ramp_q) - ramp_step);
            end else begin
                ramp_q <= 48'(ramp_tgt <<< `VFREF_FRAC_BITS);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // final voltage and frequency
    always_comb begin
        base = (sep_full || sep_semi) ? ramp_now : curve_volt + boost_add;
        ovx_add = i_decel ? base * lim(w_t'(cfg_q[`VFREF_REG_OVX]), 48'h0, `VFREF_OVX_MAX) / `VFREF_PM_FULL
                          : 48'h0;
        osc_sub = w_t'(i_osc_current) * lim(w_t'(cfg_q[`VFREF_REG_OSC]), 48'h0, `VFREF_OSC_MAX)
                  / `VFREF_OSC_MAX;
        volt_d = lim(base + ovx_add - osc_sub, 48'h0, vb);
        // rated slip in 0.01 Hz from rated frequency, speed and pole pairs
        slip_rated = lim(fb - w_t'(cfg_q[`VFREF_REG_RATED_RPM]) * w_t'(cfg_q[`VFREF_REG_POLES])
                     * 48'h64 / 48'h3C, 48'h0, fb);
        freq_d = f + slip_rated * lim(w_t'(cfg_q[`VFREF_REG_SLIP]), 48'h0, `VFREF_SLIP_MAX)
                 / `VFREF_PM_FULL * w_t'(i_load_pct) / `VFREF_PM_FULL;
        if (sep_full) begin
            freq_d = f;
        end
        freq_d = lim(freq_d, 48'h0, 48'hFFFF);
    end

    // updated only on the control tick, held between
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cmd <= '0;
            o_vf_active <= 1'b0;
        end else if (tick_q) begin
            o_vf_active <= !i_vector_mode;
            if (i_vector_mode) begin
                o_cmd.volt <= 16'h0000;
                o_cmd.freq <= i_freq_cmd;
            end else begin
                o_cmd.volt <= 16'(volt_d);
                o_cmd.freq <= 16'(freq_d);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_tick_vector;
        tick_q && i_vector_mode;
    endsequence

    sequence s_scalar_update;
        tick_q && !i_vector_mode;
    endsequence

    chk_vector_off: assert property (s_tick_vector |=> o_cmd.volt == 16'h0000 && !o_vf_active)
        else $error("voltage not zero under vector control");
    chk_scalar_load: assert property (s_scalar_update |=> o_cmd.volt == 16'($past(volt_d)) && o_vf_active)
        else $error("voltage command not loaded on tick");
    chk_hold_between: assert property (!tick_q |=> $stable(o_cmd))
        else $error("voltage command moved between ticks");
    chk_volt_clamp: assert property (o_cmd.volt <= cfg_q[`VFREF_REG_RATED_V] || $changed(cfg_q[`VFREF_REG_RATED_V])
                                     || $past(tick_q) == 1'b0 && $past(o_cmd.volt) != o_cmd.volt)
        else $error("voltage command above rated voltage");
    chk_boost_cut: assert property (f >= w_t'(cfg_q[`VFREF_REG_CUTOFF]) |-> boost_add == 48'h0)
        else $error("boost applied above cut-off");
    chk_digital_src: assert property (src_sel == `VFREF_SRC_DIGITAL && sep_full
                                      |-> ramp_tgt == lim(w_t'(cfg_q[`VFREF_REG_SETPT]), 48'h0, vb))
        else $error("digital setpoint not used");
    chk_abs_source: assert property (src_sel == 4'h1 && i_src.analog_in_one < 0
                                     && i_src.analog_in_one > -16'sd1000 |-> sep_pct == -w_t'(i_src.analog_in_one))
        else $error("negative source not taken as magnitude");
    chk_ovx_zero: assert property (!i_decel || cfg_q[`VFREF_REG_OVX] == 16'h0000 |-> ovx_add == 48'h0)
        else $error("over-excitation active when disabled");
    chk_osc_zero: assert property (cfg_q[`VFREF_REG_OSC] == 16'h0000 |-> osc_sub == 48'h0)
        else $error("damping active at zero gain");
    chk_full_freq: assert property ((s_scalar_update and sep_full) |=> o_cmd.freq == $past(i_freq_cmd))
        else $error("frequency altered in full separation");
    chk_ramp_bound: assert property (tick_q && sep_full && cfg_q[`VFREF_REG_RISE] != 16'h0000
                                     |=> w_t'(ramp_q) - w_t'($past(ramp_q)) <= $past(ramp_step))
        else $error("separation ramp stepped too far");
endmodule

`default_nettype wire

// ===== bench/vfref_drive_model.sv
// vfref_drive_model: modulator stage and pulse-train source beside the v/f block
// assumes: one clock; pulse half period counted in clock cycles, 0 = idle
`timescale 1ns/1ps
`default_nettype none

module vfref_drive_model
    import vfref_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire vfref_cmd_t i_cmd,
    input wire logic [15:0] i_pulse_half,
    output logic o_pulse,
    output vfref_cmd_t o_applied
);
    logic [15:0] cnt_q;
    // train stands low while no rate is asked
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst || i_pulse_half == 16'h0000) begin
            cnt_q <= 16'h0000;
            o_pulse <= 1'b0;
        end else if (cnt_q + 16'h0001 >= i_pulse_half) begin
            cnt_q <= 16'h0000;
            o_pulse <= ~o_pulse;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    // the stage applies whatever the modulator was last told
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) o_applied <= '0;
        else o_applied <= i_cmd;
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// testbench: register-port tasks and command checks for vfref_gen
// assumes: short control period and pulse gate set by parameters below
`timescale 1ns/1ps
`default_nettype none

module testbench
    import vfref_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd_s = 1'b0, vec = 1'b0, dec = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000, fcmd = 16'h0000, rdata, half = 16'h0000;
    logic [3:0] pins = 4'h0;
    logic pulse, act;
    vfref_src_t src = '{16'hFE0C, 16'h00FA, 16'h02EE, 16'h0064, 16'h03E8, 16'hFC18};
    vfref_cmd_t cmd;
    int error_cnt = 0, cmd_i, cmp_count = 0;
    logic [3:0] pw [4] = '{4'h3, 4'h4, 4'h6, 4'h8};
    logic [3:0] sc [6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8};
    logic [15:0] sv [6] = '{16'h06E0, 16'h0370, 16'h0A50, 16'h0160, 16'h0DC0, 16'h0DC0};

    always #2.5 clk = ~clk;

    vfref_gen #(.CTRL_CYCLES(20), .PULSE_GATE_CYCLES(2000), .MSTEP_DEPTH(16)) dut (.i_sys_clk(clk),
        .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd_s),
        .o_reg_rdata(rdata), .i_vector_mode(vec), .i_decel(dec), .i_freq_cmd(fcmd),
        .i_load_pct(16'h0000), .i_osc_current(16'sh0000), .i_src(src), .i_pulse_input_pin(pulse),
        .i_mstep_pins(pins), .o_cmd(cmd), .o_vf_active(act));
    vfref_drive_model part (.i_sys_clk(clk), .i_sys_rst(rst), .i_cmd(cmd), .i_pulse_half(half),
        .o_pulse(pulse), .o_applied());

    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        rd_s <= 1'b1; addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // seventy clock cycles, three and a half control periods, let the new setting reach the output
    task automatic run(input logic [15:0] f);
        @(posedge clk);
        fcmd <= f;
        repeat (70) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1 chk(cmd.volt, 16'h0000);
        chk({15'h0000, act}, 16'h0000);
        rreg(5'h10, 16'h0DC0);
        rreg(5'h02, 16'h1388);
        rreg(5'h0E, 16'h0000);
        rreg(5'h1F, 16'h0000);
        wreg(5'h01, 16'h0064);
        run(16'h09C4);
        chk(cmd.volt, 16'h0840);
        chk(cmd.freq, 16'h09C4);
        chk({15'h0000, act}, 16'h0001);
        wreg(5'h02, 16'h0000);
        run(16'h09C4);
        chk(cmd.volt, 16'h06E0);
        run(16'h2710);
        chk(cmd.volt, 16'h0DC0);
        wreg(5'h00, 16'h0002);
        run(16'h09C4);
        chk(cmd.volt, 16'h0370);
        for (cmd_i = 0; cmd_i < 4; cmd_i++) begin
            wreg(5'h00, {12'h000, pw[cmd_i]});
            run(16'h09C4);
            chk(cmd.volt, 16'h06E0 - 16'h00B0 * 16'(cmd_i + 1));
        end
        wreg(5'h03, 16'h03E8); wreg(5'h04, 16'h00C8); wreg(5'h05, 16'h07D0);
        wreg(5'h06, 16'h0190); wreg(5'h07, 16'h0FA0); wreg(5'h08, 16'h0320);
        wreg(5'h00, 16'h0001);
        run(16'h0BB8);
        chk(cmd.volt, 16'h0840);
        dec <= 1'b1;
        run(16'h0BB8);
        chk(cmd.volt, 16'h0840);
        dec <= 1'b0;
        vec <= 1'b1;
        run(16'h09C4);
        chk(cmd.volt, 16'h0000);
        chk({15'h0000, act}, 16'h0000);
        vec <= 1'b0;
        wreg(5'h00, 16'h000A);
        wreg(5'h0E, 16'h03E8);
        run(16'h0BB8);
        chk(cmd.volt, 16'h03E8);
        chk(cmd.freq, 16'h0BB8);
        for (cmd_i = 0; cmd_i < 6; cmd_i++) begin
            wreg(5'h0D, {12'h000, sc[cmd_i]});
            run(16'h0BB8);
            chk(cmd.volt, sv[cmd_i]);
        end
        wreg(5'h17, 16'h31F4);
        pins <= 4'h3;
        wreg(5'h0D, 16'h0005);
        run(16'h0BB8);
        chk(cmd.volt, 16'h06E0);
        half <= 16'h0014;
        wreg(5'h0D, 16'h0004);
        repeat (6000) @(posedge clk);
        #1 chk(16'((cmd.volt > 16'h06BC) && (cmd.volt < 16'h0704)), 16'h0001);
        wreg(5'h00, 16'h000B);
        wreg(5'h0D, 16'h0002);
        run(16'h07D0);
        chk(cmd.volt, 16'h02C0);
        report_and_stop();
    end
endmodule
`default_nettype wire
